// File: rtl/osd_defs.vh
`ifndef OSD_DEFS_VH
`define OSD_DEFS_VH

`define OSD_CLK_PERIOD_PS 25000
`define OSD_BLANK_TIME_NS 90000
`define OSD_RETRY_TIME_NS 11000000
`define OSD_BLANK_CYCLES ((`OSD_BLANK_TIME_NS * 1000 + `OSD_CLK_PERIOD_PS - 1) / `OSD_CLK_PERIOD_PS)
`define OSD_RETRY_CYCLES (`OSD_RETRY_TIME_NS / (`OSD_CLK_PERIOD_PS / 1000))
`define OSD_CRC_POLY 7'h37
`define OSD_CRC_INIT 7'h7f
`define OSD_SHORT_BITS 5'h08
`define OSD_LONG_BITS 5'h10
`define OSD_CHECK_BITS 5'h08
`define OSD_SHIFT_BITS 5'h18
`define OSD_MODE_RST 8'h00
`define OSD_DRIVE_RST 8'h00
`define OSD_OLD_RST 8'h00

`endif

// File: rtl/osd_pp_guard.v
`timescale 1ns/10ps
// Push-pull overload guard for one channel: blanking, then retry periods
module osd_pp_guard #(
    parameter BLANK_CYCLES = 3600,
    parameter RETRY_CYCLES = 440000
) (
    input wire ref_clk,
    input wire rst_n,
    input wire pp_active,
    input wire mismatch,
    output reg fault_r
);
    localparam ST_RUN = 2'h0;
    localparam ST_BLANK = 2'h1;
    localparam ST_RETRY = 2'h2;

    reg [1:0] state_r;
    reg [31:0] cnt_r;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
            cnt_r <= 32'h0;
            fault_r <= 1'b0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    cnt_r <= 32'h0;
                    if (pp_active && mismatch)
                        state_r <= ST_BLANK;
                end
                ST_BLANK: begin
                    if (!pp_active || !mismatch) begin
                        state_r <= ST_RUN;
                    end else if (cnt_r >= BLANK_CYCLES - 1) begin
                        state_r <= ST_RETRY;
                        cnt_r <= 32'h0;
                        fault_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                ST_RETRY: begin
                    if (!pp_active) begin
                        state_r <= ST_RUN;
                        fault_r <= 1'b0;
                    end else if (cnt_r >= RETRY_CYCLES - 1) begin
                        cnt_r <= 32'h0;
                        // With push-pull still on, cleared only at period end and only if gone
                        if (!mismatch) begin
                            state_r <= ST_RUN;
                            fault_r <= 1'b0;
                        end
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                    fault_r <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: rtl/osd_serial_port.v
`timescale 1ns/10ps
`include "osd_defs.vh"
module osd_serial_port #(
    parameter CHANNELS = 8,
    parameter BLANK_CYCLES = `OSD_BLANK_CYCLES,
    parameter RETRY_CYCLES = `OSD_RETRY_CYCLES
) (
    input wire ref_clk,
    input wire rst_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdi,
    output reg spi_sdo_r,
    output wire spi_sdo_oe,
    input wire serial_select,
    input wire long_frame_select,
    input wire config_frame_select,
    input wire check_enable_pin,
    input wire openload_force_pin,
    input wire pushpull_force_pin,
    input wire [7:0] parallel_in,
    input wire [7:0] thermal_sd,
    input wire [7:0] out_above_thr,
    input wire uvlo,
    output reg check_error_out,
    output reg fault_n,
    output reg [7:0] drive_on_r,
    output reg [7:0] pp_mode_r,
    output reg [7:0] openload_en_r
);
    // Every pin but rst_n passes two flops before use
    reg [5:0] sync1_r;
    reg [5:0] sync2_r;
    reg sclk_d_r;
    reg cs_d_r;
    wire sclk_s = sync2_r[0];
    wire cs_s = sync2_r[1];
    wire sdi_s = sync2_r[2];
    wire sel_s = sync2_r[3];
    wire long_s = sync2_r[4];
    wire cfg_s = sync2_r[5];
    reg [3:0] pin_sync1_r;
    reg [3:0] pin_sync2_r;
    reg [7:0] par_sync1_r;
    reg [7:0] par_sync2_r;
    reg [7:0] ts_sync1_r;
    reg [7:0] ts_sync2_r;
    reg [7:0] thr_sync1_r;
    reg [7:0] thr_sync2_r;
    wire chk_s = pin_sync2_r[0];
    wire olf_s = pin_sync2_r[1];
    wire ppf_s = pin_sync2_r[2];
    wire uvlo_s = pin_sync2_r[3];

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_r <= 6'h02;
            sync2_r <= 6'h02;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            pin_sync1_r <= 4'h0;
            pin_sync2_r <= 4'h0;
            par_sync1_r <= 8'h00;
            par_sync2_r <= 8'h00;
            ts_sync1_r <= 8'h00;
            ts_sync2_r <= 8'h00;
            thr_sync1_r <= 8'h00;
            thr_sync2_r <= 8'h00;
        end else begin
            sync1_r <= {config_frame_select, long_frame_select, serial_select,
                        spi_sdi, spi_cs_n, spi_sclk};
            sync2_r <= sync1_r;
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
            pin_sync1_r <= {uvlo, pushpull_force_pin, openload_force_pin, check_enable_pin};
            pin_sync2_r <= pin_sync1_r;
            par_sync1_r <= parallel_in;
            par_sync2_r <= par_sync1_r;
            ts_sync1_r <= thermal_sd;
            ts_sync2_r <= ts_sync1_r;
            thr_sync1_r <= out_above_thr;
            thr_sync2_r <= thr_sync1_r;
        end
    end

    // Clock idles low; rise samples, fall shifts out
    wire sclk_rise = sclk_s && !sclk_d_r && !cs_s;
    wire sclk_fall = !sclk_s && sclk_d_r && !cs_s;
    wire cs_fall = !cs_s && cs_d_r;
    wire cs_rise = cs_s && !cs_d_r;

    // Effective channel configuration
    reg [7:0] mode_cfg_r;
    reg [7:0] ol_cfg_r;
    wire [7:0] pp_eff = ppf_s ? 8'hff : mode_cfg_r;
    wire [7:0] ol_eff = ((sel_s && olf_s) ? 8'hff : ol_cfg_r) & ~pp_eff;
    wire [7:0] drive_eff;
    reg [7:0] drive_ser_r;
    assign drive_eff = sel_s ? drive_ser_r : par_sync2_r;

    // Open-load only when high-side, off and above threshold
    wire [7:0] openload = ol_eff & ~drive_eff & thr_sync2_r;
    wire [7:0] pp_mismatch = pp_eff & (drive_eff ^ thr_sync2_r);
    wire [7:0] pp_fault;

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
            osd_pp_guard #(
                .BLANK_CYCLES(BLANK_CYCLES),
                .RETRY_CYCLES(RETRY_CYCLES)
            ) u_guard (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .pp_active(pp_eff[gi]),
                .mismatch(pp_mismatch[gi]),
                .fault_r(pp_fault[gi])
            );
        end
    endgenerate

    wire [7:0] ch_fault = ts_sync2_r | openload | (pp_fault & pp_eff);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_n <= 1'b1;
            drive_on_r <= `OSD_DRIVE_RST;
            pp_mode_r <= `OSD_MODE_RST;
            openload_en_r <= `OSD_OLD_RST;
        end else begin
            fault_n <= ~(|ch_fault);
            drive_on_r <= drive_eff & ~(pp_fault & pp_eff);
            pp_mode_r <= pp_eff;
            openload_en_r <= ol_eff;
        end
    end

    // CRC step over one bit, MSB-first feedback
    function [6:0] crc_step;
        input [6:0] crc;
        input din;
        reg fb;
        begin
            fb = crc[6] ^ din;
            crc_step = {crc[5:0], 1'b0} ^ (fb ? `OSD_CRC_POLY : 7'h00);
        end
    endfunction

    // Frame state
    reg [23:0] tx_r;
    reg [23:0] rx_r;
    reg [4:0] frame_len_r;
    reg err_echo_r;
    reg active_r;
    reg frame_long_r;
    reg frame_chk_r;
    reg frame_cfg_r;

    wire [4:0] data_bits = long_s ? `OSD_LONG_BITS : `OSD_SHORT_BITS;
    wire use_chk = sel_s && chk_s;
    // Pairs are fault then level, channel eight first
    wire [15:0] pair_word = {ch_fault[7], thr_sync2_r[7] & ~ch_fault[7],
                             ch_fault[6], thr_sync2_r[6] & ~ch_fault[6],
                             ch_fault[5], thr_sync2_r[5] & ~ch_fault[5],
                             ch_fault[4], thr_sync2_r[4] & ~ch_fault[4],
                             ch_fault[3], thr_sync2_r[3] & ~ch_fault[3],
                             ch_fault[2], thr_sync2_r[2] & ~ch_fault[2],
                             ch_fault[1], thr_sync2_r[1] & ~ch_fault[1],
                             ch_fault[0], thr_sync2_r[0] & ~ch_fault[0]};
    wire [15:0] status16 = uvlo_s ? 16'hffff : pair_word;
    wire [7:0] status8 = uvlo_s ? 8'hff : ch_fault;

    // Outgoing check over status and the error echo bit
    reg [6:0] out_crc;
    integer k;
    always @* begin
        out_crc = `OSD_CRC_INIT;
        for (k = 15; k >= 0; k = k - 1) begin
            if (long_s || k < 8)
                out_crc = crc_step(out_crc, long_s ? status16[k] : status8[k]);
        end
        out_crc = crc_step(out_crc, err_echo_r);
    end

    // Incoming check over data bits and the leading one
    reg [6:0] in_crc;
    integer m;
    always @* begin
        in_crc = `OSD_CRC_INIT;
        for (m = 23; m >= 8; m = m - 1) begin
            if (frame_long_r || m < 16)
                in_crc = crc_step(in_crc, rx_r[m]);
        end
        in_crc = crc_step(in_crc, rx_r[7]);
    end
    wire check_ok = (rx_r[7] == 1'b1) && (in_crc == rx_r[6:0]);

    // Own bits leave first, then what came in, so a chained part sees it next
    reg [23:0] tx_shift;
    always @* begin
        tx_shift = {tx_r[22:0], 1'b0};
        tx_shift[`OSD_SHIFT_BITS - frame_len_r] = rx_r[0];
    end

    assign spi_sdo_oe = active_r;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_r <= 24'h0;
            rx_r <= 24'h0;
            frame_len_r <= `OSD_SHORT_BITS;
            err_echo_r <= 1'b0;
            active_r <= 1'b0;
            frame_long_r <= 1'b0;
            frame_chk_r <= 1'b0;
            frame_cfg_r <= 1'b0;
            spi_sdo_r <= 1'b0;
            check_error_out <= 1'b0;
            mode_cfg_r <= `OSD_MODE_RST;
            ol_cfg_r <= `OSD_OLD_RST;
            drive_ser_r <= `OSD_DRIVE_RST;
        end else begin
            if (cs_fall) begin
                // Snapshot status, MSB first, check byte last
                active_r <= 1'b1;
                frame_long_r <= long_s;
                frame_chk_r <= use_chk;
                frame_cfg_r <= cfg_s;
                frame_len_r <= data_bits + (use_chk ? `OSD_CHECK_BITS : 5'h00);
                if (long_s) begin
                    tx_r <= {status16, err_echo_r, out_crc};
                    spi_sdo_r <= status16[15];
                end else begin
                    tx_r <= {status8, err_echo_r, out_crc, 8'h00};
                    spi_sdo_r <= status8[7];
                end
            end else if (sclk_rise && active_r) begin
                rx_r <= {rx_r[22:0], sdi_s};
            end else if (sclk_fall && active_r) begin
                // Shifted-in bits trail out, so devices chain
                tx_r <= tx_shift;
                spi_sdo_r <= tx_r[22];
            end else if (cs_rise && active_r) begin
                active_r <= 1'b0;
                spi_sdo_r <= 1'b0;
                if (!frame_chk_r || check_ok) begin
                    if (frame_chk_r)
                        check_error_out <= 1'b0;
                    err_echo_r <= 1'b0;
                    // Latch on chip select rise
                    if (!frame_chk_r) begin
                        if (frame_long_r && frame_cfg_r) begin
                            ol_cfg_r <= {rx_r[15], rx_r[13], rx_r[11], rx_r[9],
                                         rx_r[7], rx_r[5], rx_r[3], rx_r[1]};
                            mode_cfg_r <= {rx_r[14], rx_r[12], rx_r[10], rx_r[8],
                                           rx_r[6], rx_r[4], rx_r[2], rx_r[0]};
                        end else if (frame_long_r && sel_s) begin
                            drive_ser_r <= rx_r[15:8];
                            mode_cfg_r <= rx_r[7:0];
                        end else if (frame_cfg_r && sel_s) begin
                            mode_cfg_r <= rx_r[7:0];
                        end else if (sel_s) begin
                            drive_ser_r <= rx_r[7:0];
                        end
                    end else begin
                        if (frame_long_r && frame_cfg_r) begin
                            ol_cfg_r <= {rx_r[23], rx_r[21], rx_r[19], rx_r[17],
                                         rx_r[15], rx_r[13], rx_r[11], rx_r[9]};
                            mode_cfg_r <= {rx_r[22], rx_r[20], rx_r[18], rx_r[16],
                                           rx_r[14], rx_r[12], rx_r[10], rx_r[8]};
                        end else if (frame_long_r) begin
                            drive_ser_r <= rx_r[23:16];
                            mode_cfg_r <= rx_r[15:8];
                        end else if (frame_cfg_r) begin
                            mode_cfg_r <= rx_r[15:8];
                        end else begin
                            drive_ser_r <= rx_r[15:8];
                        end
                    end
                end else begin
                    // Frame dropped; settings stay as they were
                    check_error_out <= 1'b1;
                    err_echo_r <= 1'b1;
                end
            end
        end
    end
endmodule

// File: test/osd_serial_port_sva.sv
`timescale 1ns/10ps
module osd_port_chk (
    input wire ref_clk,
    input wire rst_n,
    input wire spi_cs_n,
    input wire spi_sdo_oe,
    input wire openload_force_pin,
    input wire pushpull_force_pin,
    input wire [7:0] thermal_sd,
    input wire [7:0] out_above_thr,
    input wire check_error_out,
    input wire fault_n,
    input wire [7:0] drive_on_r,
    input wire [7:0] pp_mode_r,
    input wire [7:0] openload_en_r
);
    // Five cycles cover the two-flop synchronisers plus the output register
    wire ol_hit = |(openload_en_r & ~pp_mode_r & ~drive_on_r & out_above_thr);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_oe_idle: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
        else $error("sdo driven while idle");
    a_oe_frame: assert property ($fell(spi_cs_n) |-> ##[1:4] spi_sdo_oe)
        else $error("sdo not enabled");
    a_fault_heat: assert property ((|thermal_sd) [*5] |-> !fault_n)
        else $error("no fault on heat");
    a_fault_open: assert property (ol_hit [*5] |-> !fault_n)
        else $error("no fault on open load");
    a_pp_force: assert property (pushpull_force_pin [*5] |-> pp_mode_r == 8'hff)
        else $error("force not push-pull");
    a_ol_force: assert property (openload_force_pin [*5] |-> openload_en_r == ~pp_mode_r)
        else $error("open-load force missed");
    a_latch_cs: assert property ($changed(drive_on_r) && pp_mode_r == 8'h00 |-> spi_cs_n)
        else $error("drive changed mid frame");
    a_cerr_edge: assert property ($changed(check_error_out) |-> $past(spi_cs_n, 3))
        else $error("check error moved mid frame");
endmodule

bind osd_serial_port osd_port_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe), .openload_force_pin(openload_force_pin),
    .pushpull_force_pin(pushpull_force_pin), .thermal_sd(thermal_sd),
    .out_above_thr(out_above_thr), .check_error_out(check_error_out), .fault_n(fault_n),
    .drive_on_r(drive_on_r), .pp_mode_r(pp_mode_r), .openload_en_r(openload_en_r));

// File: test/osd_spi_host.sv
`timescale 1ns/10ps
// Controller side; the link clock stands low between frames
module osd_spi_host (
    input wire ref_clk,
    input wire sdo_line,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdi,
    output logic rx_valid,
    output logic [31:0] rx_word
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b1;
        rx_valid = 1'b0;
        rx_word = 32'h0;
    end
    task automatic xfer(input logic [31:0] tx, input int n);
        logic [31:0] rx;
        rx = 32'h0;
        @(negedge ref_clk);
        spi_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spi_sdi = tx[i];
            repeat (4) @(negedge ref_clk);
            spi_sclk = 1'b1;
            rx = {rx[30:0], sdo_line};
            repeat (4) @(negedge ref_clk);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        spi_cs_n = 1'b1;
        // Idle data line toggles so a stale bit cannot pass for a good one
        spi_sdi = ~spi_sdi;
        rx_word = rx;
        rx_valid = 1'b1;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule

// File: test/tb_octal_switch_serial_diag_port.sv
`timescale 1ns/10ps
module tb_octal_switch_serial_diag_port;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic long_frame_select = 1'b0, config_frame_select = 1'b0, check_enable_pin = 1'b0;
    logic openload_force_pin = 1'b0, pushpull_force_pin = 1'b0, uvlo = 1'b0;
    logic [7:0] thermal_sd = 8'h00, out_above_thr = 8'h00, d, o;
    logic spi_sclk, spi_cs_n, spi_sdi, rx_valid, spi_sdo_r, spi_sdo_oe, check_error_out, fault_n;
    logic [7:0] drive_on_r, pp_mode_r, openload_en_r;
    logic [31:0] rx_word, seed = 32'd58930;
    logic [31:0] exp_q[$];
    int num_errors = 0, num_checks = 0;
    wire sdo_line = spi_sdo_oe ? spi_sdo_r : 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    osd_serial_port #(.BLANK_CYCLES(5), .RETRY_CYCLES(20)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .spi_sdo_r(spi_sdo_r), .spi_sdo_oe(spi_sdo_oe),
        .serial_select(1'b1), .long_frame_select(long_frame_select),
        .config_frame_select(config_frame_select), .check_enable_pin(check_enable_pin),
        .openload_force_pin(openload_force_pin), .pushpull_force_pin(pushpull_force_pin),
        .parallel_in(8'h00), .thermal_sd(thermal_sd), .out_above_thr(out_above_thr),
        .uvlo(uvlo), .check_error_out(check_error_out), .fault_n(fault_n),
        .drive_on_r(drive_on_r), .pp_mode_r(pp_mode_r), .openload_en_r(openload_en_r));
    osd_spi_host host_u (.ref_clk(ref_clk), .sdo_line(sdo_line), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .rx_valid(rx_valid), .rx_word(rx_word));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [6:0] crc7(input logic [31:0] v, input int n);
        logic [6:0] c;
        c = 7'h7f;
        for (int i = n - 1; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((c[6] ^ v[i]) ? 7'h37 : 7'h00);
        return c;
    endfunction
    function automatic logic [31:0] ck(input logic [31:0] v, input int n, input logic b);
        logic [31:0] t;
        t = (v << 1) | 32'(b);
        return (t << 7) | 32'(crc7(t, n + 1));
    endfunction
    function automatic logic [15:0] pairs(input logic [7:0] f, input logic [7:0] s);
        for (int i = 0; i < 8; i++) pairs[2*i +: 2] = {f[i], s[i]};
    endfunction
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Inputs pass two synchronisers, so they settle before the select falls
    task automatic frame(input logic [31:0] tx, input int n, input logic [31:0] e);
        cyc(4);
        exp_q.push_back(e);
        host_u.xfer(tx, n);
    endtask
    task automatic wait_fault(input logic v, input int lim);
        int k;
        k = 0;
        while (fault_n !== v && k < lim) begin
            cyc(1);
            k++;
        end
        check("fault_n", 32'(v), 32'(fault_n));
    endtask
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (rx_valid) check("sdo_frame", exp_q.pop_front(), rx_word);
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(4);
        check("reset", 32'h4, {5'h0, drive_on_r, pp_mode_r, openload_en_r, fault_n,
            check_error_out, spi_sdo_oe});
        repeat (4) begin
            d = 8'(rnd());
            out_above_thr = 8'(rnd());
            frame(32'(d), 8, 32'h0);
            check("drive", 32'(d), 32'(drive_on_r));
            check("fault_n", 32'h1, 32'(fault_n));
        end
        out_above_thr = 8'h00;
        thermal_sd = 8'h08;
        wait_fault(1'b0, 8);
        frame(32'h0, 8, 32'h08);
        thermal_sd = 8'h00;
        long_frame_select = 1'b1;
        config_frame_select = 1'b1;
        frame(32'h0006, 16, 32'h0);
        check("modes", 32'h0201, {16'h0, pp_mode_r, openload_en_r});
        out_above_thr = 8'h01;
        wait_fault(1'b0, 8);
        long_frame_select = 1'b0;
        config_frame_select = 1'b0;
        frame(32'h0, 8, 32'h01);
        out_above_thr = 8'h00;
        wait_fault(1'b1, 8);
        openload_force_pin = 1'b1;
        cyc(5);
        check("ol_force", 32'hfd, 32'(openload_en_r));
        pushpull_force_pin = 1'b1;
        cyc(5);
        check("pp_force", 32'hff00, {16'h0, pp_mode_r, openload_en_r});
        openload_force_pin = 1'b0;
        pushpull_force_pin = 1'b0;
        frame(32'h02, 8, 32'h0);
        wait_fault(1'b0, 15);
        check("drive_off", 32'h0, 32'(drive_on_r));
        out_above_thr = 8'h02;
        cyc(12);
        check("fault_n", 32'h0, 32'(fault_n));
        wait_fault(1'b1, 30);
        check("drive_back", 32'h02, 32'(drive_on_r));
        config_frame_select = 1'b1;
        d = 8'(rnd());
        frame(32'(d), 8, 32'h0);
        check("modes", 32'(d), 32'(pp_mode_r));
        frame(32'h0, 8, 32'h0);
        config_frame_select = 1'b0;
        uvlo = 1'b1;
        cyc(5);
        check("fault_n", 32'h1, 32'(fault_n));
        frame(32'h02, 8, 32'hff);
        long_frame_select = 1'b1;
        frame(32'h0200, 16, 32'hffff);
        uvlo = 1'b0;
        d = 8'(rnd());
        o = 8'(rnd()) & 8'hfe;
        out_above_thr = o;
        frame({16'h0, d, 8'h00}, 16, {16'h0, pairs(8'h00, o)});
        check("drive", {16'h0, d, 8'h00}, {16'h0, drive_on_r, pp_mode_r});
        long_frame_select = 1'b0;
        d = 8'(rnd());
        frame({16'h0, 8'h5a, d}, 16, 32'h005a);
        check("drive", 32'(d), 32'(drive_on_r));
        check_enable_pin = 1'b1;
        frame(ck(32'h3c, 8, 1'b1), 16, ck(32'h0, 8, 1'b0));
        check("drive", 32'h3c, 32'(drive_on_r));
        frame(ck(32'hc3, 8, 1'b1) ^ 32'h1, 16, ck(32'h0, 8, 1'b0));
        check("bad_frame", 32'h13c, {23'h0, check_error_out, drive_on_r});
        frame(ck(32'h81, 8, 1'b1), 16, ck(32'h0, 8, 1'b1));
        check("good_frame", 32'h081, {23'h0, check_error_out, drive_on_r});
        final_report();
    end
endmodule
